// ### bdp_map.svh
// register offsets, field positions, reset values and timing counts of the bridge control bank
`ifndef BDP_MAP_SVH
`define BDP_MAP_SVH

// ==========================================================
// offsets (dword byte addresses)
`define BDP_DIAG_ARB_OFS 8'h40
`define BDP_RD_CTRL_OFS 8'h44

// ==========================================================
// diagnostic control, byte lane 1
`define BDP_DIAG_LANE 1
`define BDP_CHIP_RST_BIT 8
`define BDP_TEST_LSB 9
`define BDP_TEST_MSB 10
`define BDP_TEST_RST 2'h0

// ==========================================================
// arbiter grouping, byte lanes 2 and 3
`define BDP_ARB_LSB 16
`define BDP_ARB_MSB 25
`define BDP_ARB_RST 10'h200

// ==========================================================
// read transaction control, byte lane 0
`define BDP_RD_LANE 0
`define BDP_DS_MAX_LSB 6
`define BDP_US_MAX_LSB 4
`define BDP_DS_CL_BIT 2
`define BDP_US_CL_BIT 1
`define BDP_FLUSH_BIT 0
`define BDP_MAX_RST 2'h0
`define BDP_CL_EN_RST 1'b1
`define BDP_FLUSH_RST 1'b0

// ==========================================================
// prefetch figures in dwords
`define BDP_PF_STEP_DW 7'h10
`define BDP_CL_DEFAULT_DW 7'h10

// ==========================================================
// timing
`define BDP_CLK_NS 50
`define BDP_CHIP_RST_NS 400
`define BDP_CHIP_RST_CYC ((`BDP_CHIP_RST_NS + `BDP_CLK_NS - 1) / `BDP_CLK_NS)

`endif

// ### bdp_pkg.sv
// types shared by the bridge control bank
package bdp_pkg;

  // ==========================================================
  // configuration cycle as seen by the bank
  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [3:0] primary_cmd_byte_enable_n;
  } bdp_cfg_req_s;

  // ==========================================================
  // prefetch controls handed to the read datapath
  typedef struct packed {
    logic [6:0] ds_limit_dw;
    logic [6:0] us_limit_dw;
    logic ds_cl_bound;
    logic us_cl_bound;
  } bdp_prefetch_s;

  typedef enum logic [1:0] {
    BDP_SEQ_IDLE,
    BDP_SEQ_RUN
  } bdp_seq_e;

endpackage : bdp_pkg

// ### bdp_rst_seq.sv
// chip reset sequencer: holds busy for a fixed number of cycles after a start
`timescale 1ns/1ns
`include "bdp_map.svh"

module bdp_rst_seq #(
  parameter int CYCLES = `BDP_CHIP_RST_CYC
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic start_i,
  output logic busy_o
);

  // the counter is 16 bits wide, so longer resets cannot be served
  if (CYCLES < 1 || CYCLES > 65535) begin : g_bad_cycles
    $error("bdp_rst_seq: CYCLES out of range");
  end

  bdp_pkg::bdp_seq_e state_r;
  bdp_pkg::bdp_seq_e state_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  wire last_w = (cnt_r == 16'(CYCLES - 1));

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      bdp_pkg::BDP_SEQ_IDLE: begin
        cnt_nxt = 16'h0000;
        if (start_i) begin
          state_nxt = bdp_pkg::BDP_SEQ_RUN;
        end
      end
      bdp_pkg::BDP_SEQ_RUN: begin
        cnt_nxt = cnt_r + 16'h0001;
        if (last_w) begin
          state_nxt = bdp_pkg::BDP_SEQ_IDLE;
        end
      end
      default: begin
        state_nxt = bdp_pkg::BDP_SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_r <= bdp_pkg::BDP_SEQ_IDLE;
      cnt_r <= 16'h0000;
      busy_o <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      busy_o <= (state_nxt == bdp_pkg::BDP_SEQ_RUN);
    end
  end

endmodule : bdp_rst_seq

// ### bdp_ctrl_bank.sv
// device-specific control bank of the bridge: diagnostics, arbiter grouping, read control
//
// Operation
// - writing one starts chip reset, zero ignored
// - chip reset restores buffers, registers, interfaces
// - chip reset bit self-clears when done
// - chip reset drives secondary reset and bit
// - test field selects exercised counter bytes
// - reserved bits read zero, not writable
// - grouping bits map requesters 0-8, own master
// - grouping bit one means high priority
// - after reset only own master high
// - downstream prefetch limit 16 to 64 dwords
// - upstream prefetch limit 16 to 64 dwords
// - downstream cacheline bound enable, default on
// - upstream cacheline bound enable, default on
// - flush drops completions on primary posted write
// - flush clear keeps completions, normal ordering
// - byte enables select individual registers
`timescale 1ns/1ns
`include "bdp_map.svh"

module bdp_ctrl_bank #(
  parameter int CHIP_RST_CYCLES = `BDP_CHIP_RST_CYC,
  parameter int NUM_REQ = 9
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic cfg_valid_i,
  input wire bdp_pkg::bdp_cfg_req_s cfg_i,
  input wire logic sec_reset_bit_i,
  input wire logic [7:0] cacheline_size_i,
  input wire logic primary_posted_write_i,
  output logic cfg_ack_o,
  output logic [31:0] cfg_rdata_o,
  output logic chip_reset_o,
  output logic sec_reset_bit_set_o,
  output logic sec_rst_n_o,
  output logic [1:0] counter_test_o,
  output logic [2:0] counter_byte_en_o,
  output logic [NUM_REQ:0] arb_high_group_o,
  output bdp_pkg::bdp_prefetch_s prefetch_o,
  output logic np_flush_o,
  output logic np_flush_en_o
);

  // the grouping field has a fixed width in the dword, so the count cannot vary
  if (NUM_REQ != `BDP_ARB_MSB - `BDP_ARB_LSB) begin : g_bad_num_req
    $error("bdp_ctrl_bank: NUM_REQ must match the grouping field");
  end

  // ==========================================================
  // configuration decode
  wire [3:0] lane_w = ~cfg_i.primary_cmd_byte_enable_n;
  wire hit_diag_w = (cfg_i.addr[7:2] == 6'(`BDP_DIAG_ARB_OFS >> 2));
  wire hit_rd_w = (cfg_i.addr[7:2] == 6'(`BDP_RD_CTRL_OFS >> 2));
  wire wr_w = cfg_valid_i & cfg_i.we;
  // each register only sees writes through its own byte lanes
  wire wr_diag_w = wr_w & hit_diag_w & lane_w[`BDP_DIAG_LANE];
  wire wr_arb_lo_w = wr_w & hit_diag_w & lane_w[2];
  wire wr_arb_hi_w = wr_w & hit_diag_w & lane_w[3];
  wire wr_rd_w = wr_w & hit_rd_w & lane_w[`BDP_RD_LANE];

  // ==========================================================
  // chip reset
  logic chip_busy_w;
  wire chip_start_w = wr_diag_w & cfg_i.wdata[`BDP_CHIP_RST_BIT] & ~chip_busy_w;

  bdp_rst_seq #(
    .CYCLES(CHIP_RST_CYCLES)
  ) u_rst_seq (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .start_i(chip_start_w),
    .busy_o(chip_busy_w)
  );

  // configuration state is held at reset values from the second cycle of the chip reset on
  wire cfg_clear_w = srst_i | chip_busy_w;

  // ==========================================================
  // configuration registers
  logic [1:0] test_r;
  logic [NUM_REQ:0] arb_r;
  logic [1:0] ds_max_r;
  logic [1:0] us_max_r;
  logic ds_cl_en_r;
  logic us_cl_en_r;
  logic flush_en_r;

  // writes during chip reset are dropped, since the bank is being restored
  always_ff @(posedge clock_i) begin
    if (cfg_clear_w) begin
      test_r <= `BDP_TEST_RST;
    end else if (wr_diag_w) begin
      test_r <= cfg_i.wdata[`BDP_TEST_MSB:`BDP_TEST_LSB];
    end
  end

  always_ff @(posedge clock_i) begin
    if (cfg_clear_w) begin
      arb_r <= `BDP_ARB_RST;
    end else begin
      if (wr_arb_lo_w) begin
        arb_r[7:0] <= cfg_i.wdata[23:16];
      end
      if (wr_arb_hi_w) begin
        arb_r[NUM_REQ:8] <= cfg_i.wdata[`BDP_ARB_MSB:24];
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (cfg_clear_w) begin
      ds_max_r <= `BDP_MAX_RST;
      us_max_r <= `BDP_MAX_RST;
      ds_cl_en_r <= `BDP_CL_EN_RST;
      us_cl_en_r <= `BDP_CL_EN_RST;
      flush_en_r <= `BDP_FLUSH_RST;
    end else if (wr_rd_w) begin
      ds_max_r <= cfg_i.wdata[`BDP_DS_MAX_LSB +: 2];
      us_max_r <= cfg_i.wdata[`BDP_US_MAX_LSB +: 2];
      ds_cl_en_r <= cfg_i.wdata[`BDP_DS_CL_BIT];
      us_cl_en_r <= cfg_i.wdata[`BDP_US_CL_BIT];
      flush_en_r <= cfg_i.wdata[`BDP_FLUSH_BIT];
    end
  end

  // ==========================================================
  // read data
  wire [31:0] rd_diag_w = {6'h00, arb_r, 5'h00, test_r, chip_busy_w, 8'h00};
  // cacheline enables are write-only and read back as zero
  wire [31:0] rd_ctrl_w = {24'h000000, ds_max_r, us_max_r, 3'h0, flush_en_r};
  wire [31:0] rd_sel_w = hit_diag_w ? rd_diag_w : (hit_rd_w ? rd_ctrl_w : 32'h00000000);

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      cfg_ack_o <= 1'b0;
      cfg_rdata_o <= 32'h00000000;
    end else begin
      cfg_ack_o <= cfg_valid_i;
      cfg_rdata_o <= (cfg_valid_i & ~cfg_i.we) ? rd_sel_w : 32'h00000000;
    end
  end

  // ==========================================================
  // reset outputs
  // secondary reset persists after chip reset until software clears its bit
  wire sec_rst_w = chip_busy_w | sec_reset_bit_i;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      chip_reset_o <= 1'b0;
      sec_reset_bit_set_o <= 1'b0;
      sec_rst_n_o <= 1'b0;
    end else begin
      chip_reset_o <= chip_busy_w;
      sec_reset_bit_set_o <= chip_busy_w;
      sec_rst_n_o <= ~sec_rst_w;
    end
  end

  // ==========================================================
  // counter test selection
  logic [2:0] byte_en_w;
  always_comb begin
    case (test_r)
      2'h0: byte_en_w = 3'h7;
      2'h1: byte_en_w = 3'h2;
      2'h2: byte_en_w = 3'h4;
      2'h3: byte_en_w = 3'h1;
      default: byte_en_w = 3'h7;
    endcase
  end

  // ==========================================================
  // prefetch limits
  wire [6:0] ds_max_dw_w = 7'({ds_max_r, 4'h0}) + `BDP_PF_STEP_DW;
  wire [6:0] us_max_dw_w = 7'({us_max_r, 4'h0}) + `BDP_PF_STEP_DW;
  // an unprogrammed cacheline size falls back to a 64-byte boundary
  wire [6:0] cl_dw_w = (cacheline_size_i == 8'h00) ? `BDP_CL_DEFAULT_DW
                     : cacheline_size_i[6:0];
  bdp_pkg::bdp_prefetch_s pf_w;
  assign pf_w.ds_limit_dw = ds_cl_en_r ? cl_dw_w : ds_max_dw_w;
  assign pf_w.us_limit_dw = us_cl_en_r ? cl_dw_w : us_max_dw_w;
  assign pf_w.ds_cl_bound = ds_cl_en_r;
  assign pf_w.us_cl_bound = us_cl_en_r;

  // flush is not gated by chip reset: the enable is cleared from its second cycle on
  wire flush_w = flush_en_r & primary_posted_write_i;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      counter_test_o <= `BDP_TEST_RST;
      counter_byte_en_o <= 3'h7;
      arb_high_group_o <= `BDP_ARB_RST;
      prefetch_o <= '0;
      np_flush_o <= 1'b0;
      np_flush_en_o <= 1'b0;
    end else begin
      counter_test_o <= test_r;
      counter_byte_en_o <= byte_en_w;
      arb_high_group_o <= arb_r;
      prefetch_o <= pf_w;
      np_flush_o <= flush_w;
      np_flush_en_o <= flush_en_r;
    end
  end

  // ==========================================================
  // checks
  localparam int RST_CYC = CHIP_RST_CYCLES;
  // top grouping bits, watched for writes through the low lane only
  wire [NUM_REQ-8:0] arb_top_w = arb_r[NUM_REQ:8];
  logic [15:0] busy_len_r;
  logic rd_diag_r;
  logic rd_ctrl_r;
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      busy_len_r <= 16'h0000;
      rd_diag_r <= 1'b0;
      rd_ctrl_r <= 1'b0;
    end else begin
      busy_len_r <= chip_busy_w ? busy_len_r + 16'h0001 : 16'h0000;
      rd_diag_r <= cfg_valid_i & ~cfg_i.we & hit_diag_w;
      rd_ctrl_r <= cfg_valid_i & ~cfg_i.we & hit_rd_w;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  // ==========================================================
  // chip reset checks
  chk_chip_rst_start: assert property (chip_start_w |=> chip_busy_w ##1 chip_reset_o)
    else $error("chip reset write did not start reset");
  chk_zero_no_reset: assert property ((wr_diag_w & ~cfg_i.wdata[`BDP_CHIP_RST_BIT])
    |=> $stable(chip_busy_w) | ~chip_busy_w)
    else $error("writing zero started a chip reset");
  chk_rst_self_clear: assert property ($fell(chip_busy_w) |-> busy_len_r == 16'(RST_CYC))
    else $error("chip reset length wrong");
  chk_rst_bounded: assert property (chip_busy_w |-> (busy_len_r < 16'(RST_CYC)))
    else $error("chip reset ran too long");
  chk_busy_readback: assert property (rd_diag_r |-> cfg_rdata_o[8] == $past(chip_busy_w))
    else $error("chip reset bit read back wrong");
  chk_chip_out_idle: assert property (~chip_busy_w
    |=> ~chip_reset_o & ~sec_reset_bit_set_o)
    else $error("reset outputs active outside chip reset");
  chk_sec_rst_hold: assert property (chip_busy_w |=> ~sec_rst_n_o & sec_reset_bit_set_o)
    else $error("secondary reset not asserted during chip reset");
  chk_sec_release: assert property (~chip_busy_w & ~sec_reset_bit_i |=> sec_rst_n_o)
    else $error("secondary reset not released");
  chk_sec_bit_held: assert property (sec_reset_bit_i |=> ~sec_rst_n_o)
    else $error("secondary reset released while its bit is set");
  chk_cfg_restore: assert property (chip_busy_w
    |=> (arb_r == `BDP_ARB_RST) & (test_r == `BDP_TEST_RST) & ds_cl_en_r & us_cl_en_r
      & ~flush_en_r & (ds_max_r == 2'h0) & (us_max_r == 2'h0))
    else $error("registers not restored by chip reset");

  // ==========================================================
  // configuration port checks
  chk_ack_pulse: assert property (cfg_valid_i |=> cfg_ack_o)
    else $error("configuration cycle not acknowledged");
  chk_ack_idle: assert property (~cfg_valid_i
    |=> ~cfg_ack_o & (cfg_rdata_o == 32'h00000000))
    else $error("acknowledge or data without a cycle");
  chk_rsvd_zero: assert property (rd_diag_r
    |-> (cfg_rdata_o[15:11] == 5'h00) & (cfg_rdata_o[31:26] == 6'h00))
    else $error("reserved bits read non-zero");
  chk_rsvd_ctrl: assert property (rd_ctrl_r |-> cfg_rdata_o[31:8] == 24'h000000)
    else $error("reserved read control bits non-zero");
  chk_wo_read_zero: assert property (rd_ctrl_r |-> cfg_rdata_o[3:1] == 3'h0)
    else $error("write-only enables read non-zero");
  chk_diag_lane: assert property ((wr_w & hit_diag_w & ~lane_w[1] & ~chip_busy_w)
    |=> $stable(test_r))
    else $error("test field changed through a disabled lane");
  chk_arb_lane: assert property ((wr_arb_lo_w & ~wr_arb_hi_w & ~chip_busy_w)
    |=> $stable(arb_top_w))
    else $error("grouping bits changed through a disabled lane");
  chk_rd_lane: assert property ((wr_w & hit_rd_w & ~lane_w[0] & ~chip_busy_w)
    |=> $stable(flush_en_r) & $stable(ds_max_r))
    else $error("read control changed through a disabled lane");
  chk_arb_grouping: assert property ((wr_arb_hi_w & ~chip_busy_w) ##1 1'b1
    |=> arb_high_group_o[NUM_REQ] == $past(cfg_i.wdata[25], 2))
    else $error("own master grouping bit not applied");
  chk_arb_follow: assert property (1'b1 |=> arb_high_group_o == $past(arb_r))
    else $error("grouping output does not follow the register");

  // ==========================================================
  // counter test and prefetch checks
  chk_test_normal: assert property (test_r == 2'h0 |=> counter_byte_en_o == 3'h7)
    else $error("normal mode byte select wrong");
  chk_test_byte1: assert property (test_r == 2'h1 |=> counter_byte_en_o == 3'h2)
    else $error("byte one select wrong");
  chk_test_byte2: assert property (test_r == 2'h2 |=> counter_byte_en_o == 3'h4)
    else $error("byte two select wrong");
  chk_test_bytes: assert property (test_r == 2'h3 |=> counter_byte_en_o == 3'h1)
    else $error("test mode byte select wrong");
  chk_ds_limit: assert property ((~ds_cl_en_r & (ds_max_r == 2'h2))
    |=> prefetch_o.ds_limit_dw == 7'h30)
    else $error("downstream prefetch limit wrong");
  chk_ds_min: assert property ((~ds_cl_en_r & (ds_max_r == 2'h0))
    |=> prefetch_o.ds_limit_dw == 7'h10)
    else $error("downstream smallest limit wrong");
  chk_us_limit: assert property ((~us_cl_en_r & (us_max_r == 2'h3))
    |=> prefetch_o.us_limit_dw == 7'h40)
    else $error("upstream prefetch limit wrong");
  chk_us_min: assert property ((~us_cl_en_r & (us_max_r == 2'h0))
    |=> prefetch_o.us_limit_dw == 7'h10)
    else $error("upstream smallest limit wrong");
  chk_ds_cl_default: assert property ((ds_cl_en_r & (cacheline_size_i == 8'h00))
    |=> (prefetch_o.ds_limit_dw == 7'h10) & prefetch_o.ds_cl_bound)
    else $error("downstream default boundary wrong");
  chk_ds_cl_size: assert property ((ds_cl_en_r & (cacheline_size_i != 8'h00))
    |=> prefetch_o.ds_limit_dw == 7'($past(cacheline_size_i)))
    else $error("downstream cacheline boundary wrong");
  chk_us_cl_default: assert property ((us_cl_en_r & (cacheline_size_i == 8'h00))
    |=> (prefetch_o.us_limit_dw == 7'h10) & prefetch_o.us_cl_bound)
    else $error("upstream default boundary wrong");
  chk_us_cl_size: assert property ((us_cl_en_r & (cacheline_size_i != 8'h00))
    |=> prefetch_o.us_limit_dw == 7'($past(cacheline_size_i)))
    else $error("upstream cacheline boundary wrong");
  chk_flush_pulse: assert property (primary_posted_write_i
    |=> np_flush_o == $past(flush_en_r))
    else $error("flush did not follow posted write");
  chk_np_en_follow: assert property (flush_en_r |=> np_flush_en_o)
    else $error("flush enable output not set");
  chk_flush_off: assert property (~flush_en_r |=> ~np_flush_o & ~np_flush_en_o)
    else $error("flush active while disabled");

  // ==========================================================
  // main scenarios
  cov_chip_reset: cover property ($rose(chip_busy_w) ##[1:20] $fell(chip_busy_w));
  cov_flush: cover property (flush_en_r & primary_posted_write_i);
  cov_arb_write: cover property (wr_arb_lo_w & wr_arb_hi_w);
  cov_cl_bound: cover property (ds_cl_en_r & (cacheline_size_i == 8'h00));
  cov_test_mode: cover property (test_r == 2'h3);

endmodule : bdp_ctrl_bank

// ### bdp_host_model.sv
// host model: issues configuration cycles and holds the bridge secondary reset bit
`timescale 1ns/1ns

module bdp_host_model (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic set_req_i,
  input wire logic cfg_ack_i,
  input wire logic [31:0] cfg_rdata_i,
  output logic cfg_valid_o,
  output bdp_pkg::bdp_cfg_req_s cfg_o,
  output logic sec_reset_bit_o
);
  logic clr_req;

  initial begin
    cfg_valid_o = 1'b0;
    cfg_o = '0;
    clr_req = 1'b0;
  end

  // ==========================================================
  // secondary reset bit: set by the bank, cleared by software or by srst_i
  always_ff @(posedge clock_i) begin
    if (srst_i) sec_reset_bit_o <= 1'b0;
    else if (set_req_i) sec_reset_bit_o <= 1'b1;
    else if (clr_req) sec_reset_bit_o <= 1'b0;
  end

  // ==========================================================
  // one data phase per access; answer taken before anything changes
  task automatic cfg(input logic we, input logic [7:0] addr, input logic [3:0] be_n,
                     input logic [31:0] wdata, output logic [31:0] rdata, output logic ack);
    @(negedge clock_i);
    cfg_valid_o = 1'b1;
    cfg_o = '{we: we, addr: addr, wdata: wdata, primary_cmd_byte_enable_n: be_n};
    @(negedge clock_i);
    ack = cfg_ack_i;
    rdata = cfg_rdata_i;
    cfg_valid_o = 1'b0;
    // released lines show the inverse so a stale request never looks current
    cfg_o = ~cfg_o;
  endtask : cfg

  task automatic clear_sec_bit();
    @(negedge clock_i);
    clr_req = 1'b1;
    @(negedge clock_i);
    clr_req = 1'b0;
  endtask : clear_sec_bit
endmodule : bdp_host_model

// ### bdp_tb.sv
// self-checking bench of the bridge control bank against a behavioural model
`timescale 1ns/1ns

module tb;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic ppw = 1'b0;
  logic [7:0] cls = 8'h0;
  logic cfg_valid, ack, sec_bit, chip_reset, sec_set, sec_rst_n, np_flush, fl_en;
  logic [31:0] rdata;
  logic [1:0] ctest;
  logic [2:0] cbe;
  logic [9:0] arb_hi;
  bdp_pkg::bdp_cfg_req_s cfg;
  bdp_pkg::bdp_prefetch_s pf;
  int arb = 512, tst = 0, ds = 0, us = 0, dcl = 1, ucl = 1, fl = 0;
  int bad_count = 0, tests_run = 0, cyc = 0;

  bdp_ctrl_bank #(.CHIP_RST_CYCLES(2), .NUM_REQ(9)) i_dut (.clock_i(clock_i), .srst_i(srst_i),
    .cfg_valid_i(cfg_valid), .cfg_i(cfg), .sec_reset_bit_i(sec_bit), .cacheline_size_i(cls),
    .primary_posted_write_i(ppw), .cfg_ack_o(ack), .cfg_rdata_o(rdata),
    .chip_reset_o(chip_reset), .sec_reset_bit_set_o(sec_set), .sec_rst_n_o(sec_rst_n),
    .counter_test_o(ctest), .counter_byte_en_o(cbe), .arb_high_group_o(arb_hi),
    .prefetch_o(pf), .np_flush_o(np_flush), .np_flush_en_o(fl_en));

  bdp_host_model i_host (.clock_i(clock_i), .srst_i(srst_i), .set_req_i(sec_set),
    .cfg_ack_i(ack), .cfg_rdata_i(rdata), .cfg_valid_o(cfg_valid), .cfg_o(cfg),
    .sec_reset_bit_o(sec_bit));

  initial begin
    forever #25 clock_i = ~clock_i;
  end

  // ==========================================================
  // model
  function automatic void mdl_write(logic [7:0] a, logic [3:0] ben, logic [31:0] d);
    if (a[7:2] == 6'h10) begin
      if (!ben[1]) tst = d[10:9];
      if (!ben[2]) arb = (arb & 'h300) | d[23:16];
      if (!ben[3]) arb = (arb & 'hff) | (d[25:24] << 8);
    end
    if (a[7:2] == 6'h11 && !ben[0]) begin
      ds = d[7:6];
      us = d[5:4];
      dcl = d[2];
      ucl = d[1];
      fl = d[0];
    end
  endfunction : mdl_write

  // cacheline enables are write-only and read back as zero
  function automatic int mdl_read(logic [7:0] a);
    if (a[7:2] == 6'h10) return (arb << 16) | (tst << 9);
    if (a[7:2] == 6'h11) return (ds << 6) | (us << 4) | fl;
    return 0;
  endfunction : mdl_read

  function automatic int lim(int en, int code);
    if (en == 1) return (cls == 0) ? 16 : cls % 128;
    return 16 * (code + 1);
  endfunction : lim

  // ==========================================================
  // checks
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp

  task automatic access(input logic we, input logic [7:0] a, input logic [3:0] ben,
                        input logic [31:0] d);
    logic [31:0] rd;
    logic k;
    i_host.cfg(we, a, ben, d, rd, k);
    cmp(32'(k), 1, "ack");
    if (we) mdl_write(a, ben, d);
    else cmp(rd, mdl_read(a), "read data");
  endtask : access

  task automatic check_outs();
    int be;
    be = (tst == 0) ? 7 : (tst == 1) ? 2 : (tst == 2) ? 4 : 1;
    cmp(32'(arb_hi), arb, "grouping");
    cmp(32'(ctest), tst, "test field");
    cmp(32'(cbe), be, "counter bytes");
    cmp(32'(pf.ds_limit_dw), lim(dcl, ds), "ds limit");
    cmp(32'(pf.us_limit_dw), lim(ucl, us), "us limit");
    cmp(32'({pf.ds_cl_bound, pf.us_cl_bound}), dcl * 2 + ucl, "cl bound");
    cmp(32'(fl_en), fl, "flush enable");
  endtask : check_outs

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  // ==========================================================
  // sequence
  initial begin
    void'($urandom(78));
    repeat (5) @(posedge clock_i);
    @(negedge clock_i) srst_i = 1'b0;
    @(posedge clock_i);
    #1 check_outs();
    for (int i = 0; i < 40; i++) begin
      @(negedge clock_i) cls = $urandom_range(0, 1) ? 8'($urandom_range(0, 64)) : 8'h0;
      // chip reset bit kept clear so traffic does not wipe the bank
      access(1'b1, 8'(8'h40 + 4 * $urandom_range(0, 2)), 4'($urandom), $urandom & ~32'h100);
      access(1'b0, 8'(8'h40 + 4 * $urandom_range(0, 2)), 4'h0, 32'h0);
      @(posedge clock_i);
      #1 check_outs();
      @(negedge clock_i) ppw = 1'b1;
      @(negedge clock_i) cmp(32'(np_flush), fl, "flush pulse");
      ppw = 1'b0;
    end
    $display("test register traffic done");
    access(1'b1, 8'h40, 4'b0000, 32'h0155_0000);
    access(1'b1, 8'h40, 4'b1101, 32'h0);
    repeat (4) @(posedge clock_i);
    #1 cmp(32'(chip_reset), 0, "reset on zero");
    access(1'b1, 8'h40, 4'b1101, 32'h100);
    for (int i = 0; i < 10 && chip_reset !== 1'b1; i++) @(negedge clock_i);
    cmp(32'(chip_reset), 1, "chip reset");
    cmp(32'({sec_rst_n, sec_set}), 1, "secondary reset");
    for (int i = 0; i < 20 && chip_reset !== 1'b0; i++) @(negedge clock_i);
    arb = 512;
    {tst, ds, us, dcl, ucl, fl} = {32'd0, 32'd0, 32'd0, 32'd1, 32'd1, 32'd0};
    access(1'b0, 8'h40, 4'h0, 32'h0);
    access(1'b0, 8'h44, 4'h0, 32'h0);
    check_outs();
    cmp(32'(sec_rst_n), 0, "held after reset");
    i_host.clear_sec_bit();
    repeat (2) @(posedge clock_i);
    #1 cmp(32'(sec_rst_n), 1, "released");
    $display("test chip reset done");
    tally_and_finish();
  end
endmodule : tb
